// ===== icb_pkg.sv
/*
  shared constants and types of the internal clock block:
  register offsets, field layouts, reset values, modes.
  assumes an 8-bit register port with a 2-bit word address.
*/
package icb_pkg;
  // ==========================================================
  // register offsets
  localparam logic [1:0] ADDR_SRC_CTRL = 2'h0;
  localparam logic [1:0] ADDR_OSC_CTRL = 2'h1;
  localparam logic [1:0] ADDR_TRIM     = 2'h2;
  localparam logic [1:0] ADDR_STATUS   = 2'h3;

  // ==========================================================
  // output source select encodings
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;

  // ==========================================================
  // field layouts
  typedef struct packed {
    logic [1:0] output_source_select;
    logic [2:0] reference_divider;
    logic       reference_select;
    logic       internal_ref_output_enable;
    logic       internal_ref_stop_enable;
  } icb_src_ctrl_t;

  typedef struct packed {
    logic [1:0] bus_divider;
    logic       freq_range;
    logic       oscillator_high_gain;
    logic       low_power_bypass;
    logic       external_ref_kind;
    logic       external_ref_output_enable;
    logic       external_ref_stop_enable;
  } icb_osc_ctrl_t;

  // ==========================================================
  // reset values
  localparam icb_src_ctrl_t SRC_CTRL_RST = 8'h04;
  localparam icb_osc_ctrl_t OSC_CTRL_RST = 8'h40;
  localparam logic [7:0]    TRIM_RST     = 8'h80;
  localparam logic          FINE_TRIM_RST = 1'b0;

  // ==========================================================
  // status layout
  localparam int STAT_REF_BIT  = 4;
  localparam int STAT_MODE_LSB = 2;
  localparam int STAT_OSC_BIT  = 1;

  // ==========================================================
  // async input bundle: index of each synchronised level
  localparam int SYNC_W     = 4;
  localparam int SYNC_LOOP  = 0;
  localparam int SYNC_INT   = 1;
  localparam int SYNC_EXT   = 2;
  localparam int SYNC_OSCOK = 3;

  typedef enum logic [2:0] {
    MODE_ENG_INT    = 3'b000,
    MODE_ENG_EXT    = 3'b001,
    MODE_BYP_INT    = 3'b010,
    MODE_BYP_INT_LP = 3'b011,
    MODE_BYP_EXT    = 3'b100,
    MODE_BYP_EXT_LP = 3'b101,
    MODE_STOP       = 3'b110
  } icb_mode_t;
endpackage

// ===== icb_glitchless_sel.sv
/*
  glitch-free selector for sampled clock levels.
  assumes the source levels are already synchronised to i_core_clk.
*/
`timescale 1ns/1ps
module icb_glitchless_sel #(
  parameter int N  = 3,
  parameter int SW = 2
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_reset,
  input  wire logic [N-1:0]  i_src,
  input  wire logic [SW-1:0] i_req,
  input  wire logic [SW-1:0] i_rst_sel,
  output logic      [SW-1:0] o_cur,
  output logic               o_lvl
);
  // ==========================================================
  // selection change
  // switch only while both old and new sources sit low, so no
  // high phase is ever cut short; the low phase may stretch
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_cur <= i_rst_sel;
    end else if (i_req != o_cur && !i_src[o_cur] && !i_src[i_req]) begin
      o_cur <= i_req;  // [RULE19]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_lvl <= 1'b0;
    end else begin
      o_lvl <= i_src[o_cur];
    end
  end

  // ==========================================================
  // checks
  a_switch_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req != o_cur && (i_src[o_cur] || i_src[i_req]) |=> $stable(o_cur))  // [RULE19]
    else $error("selector switched while old source high");
endmodule

// ===== icb_clock_source.sv
/*
  internal clock block: mode control, output clock select with bus
  divider, loop reference select and divider, debug clock, reference
  enables and the register port.
  assumes loop, internal and external reference clocks arrive as slow
  levels from other domains, sampled here at 40 MHz; stop and debug
  requests come from logic on i_core_clk.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
// Overview of operation
// RULE1 - engaged external: output from loop locked to external ref, debug from loop
// RULE2 - bypassed internal: loop on with internal ref, output internal ref, debug on
// RULE3 - low-power bypassed internal: loop off, output internal ref, no debug clock
// RULE4 - bypassed external: loop on with external ref, output external ref, debug on
// RULE5 - low-power bypassed external: loop off, output external ref, no debug clock
// RULE6 - external ref may be crystal oscillator or another clock; both accepted
// RULE7 - stop: loop off, no system or debug clock, refs follow stop enables
// RULE8 - no signals leave the chip; all ports are on-chip
// RULE9 - output select 00 loop, 01 internal, 10 external; 11 acts as 00
// RULE10 - reference divider divides loop reference by 2^n; resets to divide by 1
// RULE11 - software keeps divided reference between 31.25 and 39.0625 kHz
// RULE12 - reference select 1 picks internal, 0 picks external loop reference
// RULE13 - internal ref output enable gates the internal reference clock output
// RULE14 - internal ref stop enable keeps it running in stop if used before
// RULE15 - reset enters engaged internal mode with bus divider at divide by two
// RULE16 - bus divider divides output clock by 1, 2, 4 or 8
// RULE17 - low-power bit disables loop in bypass unless background debug active
// RULE18 - mode and reference status follow only after synchronised switch
// RULE19 - output switching is glitch-free, no shortened pulse
`timescale 1ns/1ps
module icb_clock_source
  import icb_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_loop_clk,
  input  wire logic       i_int_ref_clk,
  input  wire logic       i_ext_ref_clk,
  input  wire logic       i_osc_ready,
  input  wire logic       i_stop,
  input  wire logic       i_debug_active,
  output logic      [7:0] o_rdata,
  output logic            o_sys_clk,
  output logic            o_debug_clk,
  output logic            o_loop_enable,
  output logic            o_loop_ref_clk,
  output logic            o_int_ref_clk,
  output logic            o_ext_ref_clk,
  output logic            o_int_ref_run,
  output logic            o_ext_ref_run,
  output logic            o_osc_request,
  output logic            o_osc_high_gain,
  output logic            o_osc_high_range,
  output logic      [8:0] o_trim,
  output icb_mode_t       o_mode
);
  // ==========================================================
  // synchronisers for levels from other domains
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  // all ports stay on-chip; no pad logic here  [RULE8]
  logic [SYNC_W-1:0] async_in;
  assign async_in = {i_osc_ready, i_ext_ref_clk, i_int_ref_clk, i_loop_clk};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= async_in[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // registers
  icb_src_ctrl_t src_ctrl;
  icb_osc_ctrl_t osc_ctrl;
  logic [7:0]    trim;
  logic          fine_trim;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      src_ctrl  <= SRC_CTRL_RST;  // [RULE10] [RULE15]
      osc_ctrl  <= OSC_CTRL_RST;  // [RULE16]
      trim      <= TRIM_RST;
      fine_trim <= FINE_TRIM_RST;
    end else if (i_wr) begin
      if (i_addr == ADDR_SRC_CTRL) begin
        src_ctrl <= i_wdata;
      end else if (i_addr == ADDR_OSC_CTRL) begin
        osc_ctrl <= i_wdata;
      end else if (i_addr == ADDR_TRIM) begin
        trim <= i_wdata;
      end else begin
        fine_trim <= i_wdata[0];
      end
    end
  end

  // ==========================================================
  // mode decode
  logic [1:0] src_eff;
  logic       lp_active;
  icb_mode_t  next_mode;

  // reserved select falls back to the loop output  [RULE9]
  assign src_eff = (src_ctrl.output_source_select == SRC_RSVD) ? SRC_LOOP
                 : src_ctrl.output_source_select;
  // debug keeps the loop alive even with low power set  [RULE17]
  assign lp_active = osc_ctrl.low_power_bypass && !i_debug_active;

  always_comb begin
    if (i_stop) begin
      next_mode = MODE_STOP;  // [RULE7]
    end else if (src_eff == SRC_INT) begin
      next_mode = lp_active ? MODE_BYP_INT_LP : MODE_BYP_INT;  // [RULE2] [RULE3]
    end else if (src_eff == SRC_EXT) begin
      next_mode = lp_active ? MODE_BYP_EXT_LP : MODE_BYP_EXT;  // [RULE4] [RULE5]
    end else begin
      next_mode = src_ctrl.reference_select ? MODE_ENG_INT : MODE_ENG_EXT;  // [RULE1]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_mode <= MODE_ENG_INT;  // [RULE15]
    end else begin
      o_mode <= next_mode;
    end
  end

  logic loop_on;
  assign loop_on = (o_mode == MODE_ENG_INT) || (o_mode == MODE_ENG_EXT)
                || (o_mode == MODE_BYP_INT) || (o_mode == MODE_BYP_EXT);

  // ==========================================================
  // mode held before stop, for the stop enables
  logic pre_int;
  logic pre_ext;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pre_int <= 1'b1;
      pre_ext <= 1'b0;
    end else if (o_mode != MODE_STOP) begin
      pre_int <= (o_mode == MODE_ENG_INT) || (o_mode == MODE_BYP_INT)
              || (o_mode == MODE_BYP_INT_LP);
      pre_ext <= (o_mode == MODE_ENG_EXT) || (o_mode == MODE_BYP_EXT)
              || (o_mode == MODE_BYP_EXT_LP);
    end
  end

  // ==========================================================
  // reference enables
  logic int_run;
  logic ext_run;

  always_comb begin
    if (o_mode == MODE_STOP) begin
      int_run = src_ctrl.internal_ref_stop_enable  // [RULE14]
             && (src_ctrl.internal_ref_output_enable || pre_int);
      ext_run = osc_ctrl.external_ref_stop_enable
             && (osc_ctrl.external_ref_output_enable || pre_ext);
    end else begin
      int_run = src_ctrl.internal_ref_output_enable || pre_int
             || src_ctrl.reference_select;
      ext_run = osc_ctrl.external_ref_output_enable || pre_ext
             || !src_ctrl.reference_select;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_int_ref_run    <= 1'b1;
      o_ext_ref_run    <= 1'b0;
      o_osc_request    <= 1'b0;
      o_osc_high_gain  <= 1'b0;
      o_osc_high_range <= 1'b0;
      o_trim           <= {TRIM_RST, FINE_TRIM_RST};
    end else begin
      o_int_ref_run    <= int_run;
      o_ext_ref_run    <= ext_run;
      // crystal or plain clock both feed the same reference input  [RULE6]
      o_osc_request    <= ext_run && osc_ctrl.external_ref_kind;
      o_osc_high_gain  <= osc_ctrl.oscillator_high_gain;
      o_osc_high_range <= osc_ctrl.freq_range;
      o_trim           <= {trim, fine_trim};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_int_ref_clk <= 1'b0;
      o_ext_ref_clk <= 1'b0;
    end else begin
      o_int_ref_clk <= int_run && src_ctrl.internal_ref_output_enable
                    && sync_b[SYNC_INT];  // [RULE13]
      o_ext_ref_clk <= ext_run && osc_ctrl.external_ref_output_enable
                    && sync_b[SYNC_EXT];
    end
  end

  // ==========================================================
  // loop reference select and divider
  logic [1:0] ref_src;
  logic       ref_cur;
  logic       ref_lvl;
  logic       ref_lvl_d;
  logic [6:0] ref_cnt;

  assign ref_src = {sync_b[SYNC_INT], sync_b[SYNC_EXT]};

  icb_glitchless_sel #(
    .N  (2),
    .SW (1)
  ) u_ref_sel (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_src      (ref_src),
    .i_req      (src_ctrl.reference_select),  // [RULE12]
    .i_rst_sel  (1'b1),
    .o_cur      (ref_cur),
    .o_lvl      (ref_lvl)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ref_lvl_d <= 1'b0;
      ref_cnt   <= '0;
    end else begin
      ref_lvl_d <= ref_lvl;
      if (ref_lvl && !ref_lvl_d) begin
        ref_cnt <= ref_cnt + 7'h01;
      end
    end
  end

  // counter bit k toggles every 2^k edges: divide by 2^(k+1)
  // range of the result is left to software  [RULE11]
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_loop_ref_clk <= 1'b0;
    end else if (!loop_on) begin
      o_loop_ref_clk <= 1'b0;
    end else if (src_ctrl.reference_divider == 3'h0) begin
      o_loop_ref_clk <= ref_lvl;  // [RULE10]
    end else begin
      o_loop_ref_clk <= ref_cnt[src_ctrl.reference_divider - 3'h1];  // [RULE10]
    end
  end

  // ==========================================================
  // output select and bus divider
  logic [2:0] out_src;
  logic [1:0] out_cur;
  logic       out_lvl;
  logic       out_lvl_d;
  logic [2:0] out_cnt;

  assign out_src = {sync_b[SYNC_EXT], sync_b[SYNC_INT], sync_b[SYNC_LOOP]};

  icb_glitchless_sel #(
    .N  (3),
    .SW (2)
  ) u_out_sel (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_src      (out_src),
    .i_req      (src_eff),  // [RULE9] [RULE19]
    .i_rst_sel  (SRC_LOOP),
    .o_cur      (out_cur),
    .o_lvl      (out_lvl)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      out_lvl_d <= 1'b0;
      out_cnt   <= '0;
    end else begin
      out_lvl_d <= out_lvl;
      if (out_lvl && !out_lvl_d) begin
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sys_clk <= 1'b0;
    end else if (o_mode == MODE_STOP) begin
      o_sys_clk <= 1'b0;  // [RULE7]
    end else if (osc_ctrl.bus_divider == 2'h0) begin
      o_sys_clk <= out_lvl;  // [RULE16]
    end else begin
      o_sys_clk <= out_cnt[osc_ctrl.bus_divider - 2'h1];  // [RULE16]
    end
  end

  // ==========================================================
  // loop enable and debug clock, a fixed half of the loop
  logic loop_d;
  logic dbg_div;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      loop_d  <= 1'b0;
      dbg_div <= 1'b0;
    end else begin
      loop_d <= sync_b[SYNC_LOOP];
      if (sync_b[SYNC_LOOP] && !loop_d) begin
        dbg_div <= !dbg_div;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_loop_enable <= 1'b1;
      o_debug_clk   <= 1'b0;
    end else begin
      o_loop_enable <= loop_on;  // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE7]
      o_debug_clk   <= loop_on && dbg_div;  // [RULE3] [RULE5] [RULE7]
    end
  end

  // ==========================================================
  // read port; status shows the switched selections only
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == ADDR_SRC_CTRL) begin
      o_rdata <= src_ctrl;
    end else if (i_addr == ADDR_OSC_CTRL) begin
      o_rdata <= osc_ctrl;
    end else if (i_addr == ADDR_TRIM) begin
      o_rdata <= trim;
    end else begin
      o_rdata <= '0;
      o_rdata[STAT_REF_BIT] <= ref_cur;  // [RULE18]
      o_rdata[STAT_MODE_LSB +: 2] <= out_cur;  // [RULE18]
      o_rdata[STAT_OSC_BIT] <= sync_b[SYNC_OSCOK];
      o_rdata[0] <= fine_trim;
    end
  end

  // ==========================================================
  // checks
  a_stop_no_clk: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_mode == MODE_STOP |=> !o_sys_clk && !o_debug_clk && !o_loop_enable)  // [RULE7]
    else $error("clock or loop active in stop");
  a_lp_int_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_mode == MODE_BYP_INT_LP |=> !o_loop_enable && !o_debug_clk)  // [RULE3]
    else $error("loop running in low-power internal bypass");
  a_lp_ext_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_mode == MODE_BYP_EXT_LP |=> !o_loop_enable && !o_debug_clk)  // [RULE5]
    else $error("loop running in low-power external bypass");
  a_bypass_loop_on: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_mode == MODE_BYP_INT || o_mode == MODE_BYP_EXT) |=> o_loop_enable)  // [RULE2]
    else $error("loop off in plain bypass");
  a_debug_keeps: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_stop && i_debug_active && src_eff != SRC_LOOP
    |=> o_mode == MODE_BYP_INT || o_mode == MODE_BYP_EXT)  // [RULE17]
    else $error("low power took the loop during debug");
  a_rsvd_select: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_stop && src_ctrl.output_source_select == SRC_RSVD
    |=> o_mode == MODE_ENG_INT || o_mode == MODE_ENG_EXT)  // [RULE9]
    else $error("reserved select not treated as loop");
  a_reset_state: assert property (@(posedge i_core_clk)
    $fell(i_reset) |-> src_ctrl == SRC_CTRL_RST && osc_ctrl == OSC_CTRL_RST
                     && o_mode == MODE_ENG_INT)  // [RULE15]
    else $error("wrong state after reset");
  a_bus_div_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_mode != MODE_STOP && osc_ctrl.bus_divider == 2'h0
    |=> o_sys_clk == $past(out_lvl))  // [RULE16]
    else $error("divide by one does not pass the clock");
  a_ref_div_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
    loop_on && src_ctrl.reference_divider == 3'h0
    |=> o_loop_ref_clk == $past(ref_lvl))  // [RULE10]
    else $error("reference divide by one wrong");
  a_int_ref_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !src_ctrl.internal_ref_output_enable |=> !o_int_ref_clk)  // [RULE13]
    else $error("internal reference output while disabled");
  a_stop_ref_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_mode == MODE_STOP && !src_ctrl.internal_ref_stop_enable
    |=> !o_int_ref_run)  // [RULE14]
    else $error("internal reference running in stop");
  a_status_mode: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_rd && i_addr == ADDR_STATUS
    |=> o_rdata[STAT_MODE_LSB +: 2] == $past(out_cur)
        && o_rdata[STAT_REF_BIT] == $past(ref_cur))  // [RULE18]
    else $error("status not from switched selection");

  c_eng_ext:  cover property (@(posedge i_core_clk) o_mode == MODE_ENG_EXT);
  c_byp_lp:   cover property (@(posedge i_core_clk) o_mode == MODE_BYP_EXT_LP);
  c_stop_run: cover property (@(posedge i_core_clk) o_mode == MODE_STOP && o_int_ref_run);
  c_switch:   cover property (@(posedge i_core_clk) $changed(out_cur));
endmodule

// ===== tb.sv
/*
  self-checking bench of the internal clock block: register port, modes,
  output select, dividers, reference enables, stop behaviour.
  assumes the design's own assertions; clock inputs are slow toggles.
*/
`timescale 1ns/1ps
module tb;
  import icb_pkg::*;
  // ==========================================================
  // signals
  logic       i_core_clk = 1'b0;
  logic       i_reset    = 1'b1;
  logic [1:0] i_addr     = 2'h0;
  logic [7:0] i_wdata    = 8'h00;
  logic       i_wr       = 1'b0;
  logic       i_rd       = 1'b0;
  logic       i_loop_clk = 1'b0;
  logic       i_int_ref_clk = 1'b0;
  logic       i_ext_ref_clk = 1'b0;
  logic       i_osc_ready = 1'b1;
  logic       i_stop     = 1'b0;
  logic       i_debug_active = 1'b0;
  logic [7:0] o_rdata;
  logic       o_sys_clk, o_debug_clk, o_loop_enable, o_loop_ref_clk;
  logic       o_int_ref_clk, o_ext_ref_clk, o_int_ref_run, o_ext_ref_run;
  logic       o_osc_request, o_osc_high_gain, o_osc_high_range;
  logic [8:0] o_trim;
  icb_mode_t  o_mode;
  logic [7:0] cnt = 8'h00;
  int         n_errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  wire  [4:0] probe = {o_ext_ref_clk, o_int_ref_clk, o_loop_ref_clk, o_debug_clk, o_sys_clk};

  icb_clock_source icb_clock_source_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_loop_clk(i_loop_clk),
    .i_int_ref_clk(i_int_ref_clk), .i_ext_ref_clk(i_ext_ref_clk), .i_osc_ready(i_osc_ready),
    .i_stop(i_stop), .i_debug_active(i_debug_active), .o_rdata(o_rdata),
    .o_sys_clk(o_sys_clk), .o_debug_clk(o_debug_clk), .o_loop_enable(o_loop_enable),
    .o_loop_ref_clk(o_loop_ref_clk), .o_int_ref_clk(o_int_ref_clk),
    .o_ext_ref_clk(o_ext_ref_clk), .o_int_ref_run(o_int_ref_run),
    .o_ext_ref_run(o_ext_ref_run), .o_osc_request(o_osc_request),
    .o_osc_high_gain(o_osc_high_gain), .o_osc_high_range(o_osc_high_range),
    .o_trim(o_trim), .o_mode(o_mode));

  // ==========================================================
  // clocks: loop period 8, internal 16, external 32 core cycles
  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cnt           <= cnt + 8'h01;
    i_loop_clk    <= cnt[2];
    i_int_ref_clk <= cnt[3];
    i_ext_ref_clk <= cnt[4];
  end

  // ==========================================================
  // helpers
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ceiling well above the roughly 6700 cycles the tests need
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic near(input int c, input int e);
    return (c >= e - 1) && (c <= e + 1);
  endfunction

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask

  // rising edges of one probe bit over n cycles
  task automatic rises(input int idx, input int n, output int c);
    logic p;
    c = 0;
    p = probe[idx];
    repeat (n) begin
      @(posedge i_core_clk);
      #1;
      if (probe[idx] && !p) c++;
      p = probe[idx];
    end
  endtask

  task automatic run_mode(input logic [7:0] s, input logic [7:0] o, input logic d,
                          input icb_mode_t m, input logic le, input int per);
    int         c;
    logic [7:0] r;
    i_debug_active <= d;
    wr(ADDR_OSC_CTRL, o);
    wr(ADDR_SRC_CTRL, s);
    repeat (40) @(posedge i_core_clk);
    #1;
    check(9'(o_mode), 9'(m));
    check(9'(o_loop_enable), 9'(le));
    rd(ADDR_STATUS, r);
    check(9'(r & 8'h1c), {4'h0, s[2], (s[7:6] == 2'h3) ? 2'h0 : s[7:6], 2'h0});
    rises(0, 192, c);
    check(9'(near(c, 192 / per)), 9'h001);
    rises(1, 64, c);
    check(9'(c != 0), 9'(le));
    $display("test mode %h/%h done", s, o);
  endtask

  // pre-stop setup decides which reference keeps running
  task automatic run_stop(input logic [7:0] s, input logic [7:0] o, input logic ir,
                          input logic er);
    int c;
    wr(ADDR_OSC_CTRL, o);
    wr(ADDR_SRC_CTRL, s);
    repeat (20) @(posedge i_core_clk);
    i_stop <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1;
    check(9'(o_mode), 9'(MODE_STOP));
    check(9'(o_loop_enable), 9'h000);
    check(9'(o_int_ref_run), 9'(ir));
    check(9'(o_ext_ref_run), 9'(er));
    rises(0, 64, c);
    check(9'(c), 9'h000);
    rises(1, 64, c);
    check(9'(c), 9'h000);
    @(posedge i_core_clk);
    i_stop <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    $display("test stop %h/%h done", s, o);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] r;
    logic [7:0] rst_exp [4];
    int         c;
    rst_exp = '{8'h04, 8'h40, 8'h80, 8'h12};
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    #1;
    check(9'(o_mode), 9'(MODE_ENG_INT));
    check(o_trim, 9'h100);
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), r);
      check(9'(r), 9'(rst_exp[a]));
    end
    $display("test reset done");
    run_mode(8'h00, 8'h00, 1'b0, MODE_ENG_EXT, 1'b1, 8);
    run_mode(8'h44, 8'h00, 1'b0, MODE_BYP_INT, 1'b1, 16);
    run_mode(8'h44, 8'h08, 1'b0, MODE_BYP_INT_LP, 1'b0, 16);
    run_mode(8'h80, 8'h00, 1'b0, MODE_BYP_EXT, 1'b1, 32);
    run_mode(8'h80, 8'h08, 1'b0, MODE_BYP_EXT_LP, 1'b0, 32);
    run_mode(8'hc4, 8'h00, 1'b0, MODE_ENG_INT, 1'b1, 8);
    run_mode(8'h44, 8'h08, 1'b1, MODE_BYP_INT, 1'b1, 16);
    i_debug_active <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      run_mode(8'h44, 8'(k << 6), 1'b0, MODE_BYP_INT, 1'b1, 16 << k);
    end
    // loop reference from the internal ref, period 16; scaled stand-in for legal band
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SRC_CTRL, 8'h04 | 8'(k << 3));
      repeat (20) @(posedge i_core_clk);
      rises(2, 512, c);
      check(9'(near(c, 32 >> k)), 9'h001);
    end
    // external ref as loop reference, period 32
    wr(ADDR_SRC_CTRL, 8'h00);
    repeat (40) @(posedge i_core_clk);
    rises(2, 512, c);
    check(9'(near(c, 16)), 9'h001);
    $display("test ref divider done");
    wr(ADDR_SRC_CTRL, 8'h06);
    wr(ADDR_OSC_CTRL, 8'h46);
    repeat (20) @(posedge i_core_clk);
    rises(3, 64, c);
    check(9'(c != 0), 9'h001);
    rises(4, 96, c);
    check(9'(c != 0), 9'h001);
    check(9'(o_osc_request), 9'h001);
    check({7'h00, o_osc_high_range, o_osc_high_gain}, 9'h000);
    wr(ADDR_SRC_CTRL, 8'h04);
    wr(ADDR_OSC_CTRL, 8'h72);
    repeat (20) @(posedge i_core_clk);
    rises(3, 64, c);
    check(9'(c), 9'h000);
    rises(4, 96, c);
    check(9'(c != 0), 9'h001);
    check(9'(o_osc_request), 9'h000);
    check({7'h00, o_osc_high_range, o_osc_high_gain}, 9'h003);
    $display("test ref outputs done");
    wr(ADDR_TRIM, 8'h3c);
    wr(ADDR_STATUS, 8'hff);
    repeat (2) @(posedge i_core_clk);
    check(o_trim, 9'h079);
    rd(ADDR_STATUS, r);
    check(9'(r & 8'he1), 9'h001);
    $display("test trim done");
    run_stop(8'h81, 8'h41, 1'b0, 1'b1);
    run_stop(8'h07, 8'h42, 1'b1, 1'b0);
    stop_test();
  end
endmodule
